// File: core/irq_ctrl_regs.vh
// register offsets, field positions, reset values and vector addresses
`ifndef IRQ_CTRL_REGS_VH
`define IRQ_CTRL_REGS_VH

// byte offsets on the register bus
`define OFS_EDGE_CONFIG   8'h00
`define OFS_CTRL_PRIMARY  8'h04
`define OFS_CTRL_SECOND   8'h08
`define OFS_STATUS        8'h0c

// reset values
`define RST_EDGE_CONFIG   8'h00
`define RST_CTRL_PRIMARY  8'h00
`define RST_CTRL_SECOND   8'h00
`define RST_EDGE_SEL      2'b00

// primary register fields
`define BIT_GLOBAL_EN     0
`define BIT_EXT_EN        1
`define BIT_TOUCH_EN      2
`define BIT_TIMER_EN      3
`define BIT_EXT_FLAG      4
`define BIT_TOUCH_FLAG    5
`define BIT_TIMER_FLAG    6

// edge select encodings
`define EDGE_OFF          2'b00
`define EDGE_RISE         2'b01
`define EDGE_FALL         2'b10
`define EDGE_BOTH         2'b11

// per-source vectors, priority order ext,touch,timer,serial,tick,nvm,adc
`define VEC_EXT           12'h004
`define VEC_TOUCH         12'h008
`define VEC_TIMER         12'h00c
`define VEC_SERIAL        12'h010
`define VEC_TICK          12'h014
`define VEC_NVM           12'h018
`define VEC_ADC           12'h01c

// AXI responses
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

// File: core/vectored_irq_controller.v
// vectored interrupt controller with AXI4-Lite register access
// ---------------------------------------------------------------
// Notes on behaviour
// - internal flags always set on events, the external one only while enabled; vectoring needs the source enable.
// - global enable low blocks every interrupt.
// - taken interrupt pushes next pc and loads the vector.
// - return_from_irq pops saved address into the program counter.
// - every source owns a distinct vector.
// - servicing clears global enable, stopping nesting.
// - requests during blocking still set and hold flags.
// - full stack blocks acknowledge until the pointer drops.
// - simultaneous requests follow fixed priority.
// - a newly set flag wakes sleep or idle; old flags do not.
// - edge select: 00 off, 01 rising, 10 falling, 11 both.
// - external flag sets on the selected pin transition.
// - pin is interrupt input only while its enable is set.
// - servicing external clears its flag and the global enable.
// - primary: global, ext, touch, timer enables, then three flags.
// - secondary: four enables low nibble, four flags high nibble.
// - pin pull-high selection stays valid in interrupt use.
// - servicing an internal source clears its flag too.
// - wake on any flag rising edge regardless of enables.
// ---------------------------------------------------------------
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
`include "irq_ctrl_regs.vh"

module vectored_irq_controller
(
	input  wire        clock,
	input  wire        reset,
	// AXI4-Lite slave
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// external pin and pull-high
	input  wire        extPin,
	input  wire        extPullHighSel,
	output wire        extPullHighEn,
	// internal source events, one-cycle pulses on this clock
	input  wire        touchEvent,
	input  wire        timerEvent,
	input  wire        serialEvent,
	input  wire        tickEvent,
	input  wire        nvmEvent,
	input  wire        adcEvent,
	// core interface
	input  wire        instrBoundary,
	input  wire [11:0] nextPc,
	input  wire        stackFull,
	input  wire        return_from_irq,
	input  wire [11:0] stackTop,
	output reg         pcLoad,
	output reg  [11:0] pcLoadValue,
	output reg         stackPush,
	output reg  [11:0] stackPushValue,
	output reg         stackPop,
	output reg         wakeRequest
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	reg  [1:0]  edgeSel_q;
	reg         globalEn_q;
	reg  [6:0]  srcEn_q;     // ext,touch,timer,serial,tick,nvm,adc
	reg  [6:0]  srcFlag_q;
	reg  [6:0]  srcFlagPrev_q;
	reg         pinSync1_q;
	reg         pinSync2_q;
	reg         pinLast_q;
	reg         awHeld_q;
	reg         wHeld_q;
	reg  [7:0]  awAddr_q;
	reg  [31:0] wData_q;
	reg  [3:0]  wStrb_q;

	wire [6:0]  hwEvent;
	wire        pinRise;
	wire        pinFall;
	wire        extEdgeHit;
	wire [6:0]  ready;
	wire        take;
	wire [2:0]  winner;
	wire        doWrite;
	wire [7:0]  primaryRd;
	wire [7:0]  secondRd;
	reg  [6:0]  flagSet;
	reg  [6:0]  flagClr;

	// fixed priority needs no state, so a late arrival of a higher
	// source still wins at the very next boundary
	// lowest index wins, index 0 is the external pin
	function [2:0] pickFirst;
		input [6:0] req;
		integer i;
		begin
			pickFirst = 3'd7;
			for (i = 6; i >= 0; i = i - 1)
				if (req[i])
					pickFirst = i[2:0];
		end
	endfunction

	// the index 7 meaning none never reaches this table, because a
	// take is only made while at least one source is ready
	// vector table, one distinct address per source
	function [11:0] vectorOf;
		input [2:0] idx;
		begin
			case (idx)
				3'd0:    vectorOf = `VEC_EXT;
				3'd1:    vectorOf = `VEC_TOUCH;
				3'd2:    vectorOf = `VEC_TIMER;
				3'd3:    vectorOf = `VEC_SERIAL;
				3'd4:    vectorOf = `VEC_TICK;
				3'd5:    vectorOf = `VEC_NVM;
				default: vectorOf = `VEC_ADC;
			endcase
		end
	endfunction

	// ---------------------------------------------------------------
	// external pin
	// ---------------------------------------------------------------

	// the pin is asynchronous, so only the second stage feeds logic
	// the history stage resets low with the synchroniser, so a pin held
	// high through reset shows one rising edge once reset ends
	// limitation: pulses shorter than one clock may be missed
	// two-stage synchroniser, then a history stage for edge detect
	always @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			pinSync1_q <= 1'b0;
			pinSync2_q <= 1'b0;
			pinLast_q  <= 1'b0;
		end
		else
		begin
			pinSync1_q <= extPin;
			pinSync2_q <= pinSync1_q;
			pinLast_q  <= pinSync2_q;
		end
	end

	assign pinRise = pinSync2_q & ~pinLast_q;
	assign pinFall = ~pinSync2_q & pinLast_q;
	// pin only acts as an interrupt input while its enable is set
	assign extEdgeHit = srcEn_q[0] &
		((edgeSel_q == `EDGE_RISE && pinRise) ||
		 (edgeSel_q == `EDGE_FALL && pinFall) ||
		 (edgeSel_q == `EDGE_BOTH && (pinRise || pinFall)));
	// pull-high stays in force in interrupt use
	assign extPullHighEn = extPullHighSel;

	assign hwEvent = {adcEvent, nvmEvent, tickEvent, serialEvent,
		timerEvent, touchEvent, extEdgeHit};

	// ---------------------------------------------------------------
	// arbitration
	// ---------------------------------------------------------------
	// a take needs the global enable, a ready source, room on the
	// stack and an instruction boundary, all sampled on one edge;
	// the core then sees push and load one cycle later
	// only enabled pending flags compete, so a disabled source can
	// never steal the vector of an enabled one
	// limitation: the core must hold nextPc steady at the boundary,
	// since it is captured on the take edge without a second look
	assign ready  = srcFlag_q & srcEn_q;
	assign take   = globalEn_q & (|ready) & ~stackFull & instrBoundary;
	assign winner = pickFirst(ready);

	// ---------------------------------------------------------------
	// AXI4-Lite slave
	// ---------------------------------------------------------------
	// both readies fall while a response waits, so a master cannot
	// queue a second write behind an unacknowledged one
	// limitation: one outstanding write and one outstanding read
	// wstrb lane 0 alone gates the write; upper lanes carry nothing
	// address and data are captured independently, either order
	assign s_axi_awready = ~awHeld_q & ~s_axi_bvalid;
	assign s_axi_wready  = ~wHeld_q & ~s_axi_bvalid;
	assign doWrite       = awHeld_q & wHeld_q & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;

	assign primaryRd = {1'b0, srcFlag_q[2:0], srcEn_q[2:0], globalEn_q};
	assign secondRd  = {srcFlag_q[6:3], srcEn_q[6:3]};

	always @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			awHeld_q     <= 1'b0;
			wHeld_q      <= 1'b0;
			awAddr_q     <= 8'h00;
			wData_q      <= 32'h00000000;
			wStrb_q      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp  <= `RESP_OKAY;
			s_axi_rdata  <= 32'h00000000;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHeld_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHeld_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
			if (doWrite)
			begin
				awHeld_q     <= 1'b0;
				wHeld_q      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (awAddr_q)
					`OFS_EDGE_CONFIG, `OFS_CTRL_PRIMARY,
					`OFS_CTRL_SECOND, `OFS_STATUS:
						s_axi_bresp <= `RESP_OKAY;
					default:
						s_axi_bresp <= `RESP_SLVERR;
				endcase
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			// read: one cycle after the address is taken
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `RESP_OKAY;
				case (s_axi_araddr)
					`OFS_EDGE_CONFIG:
						s_axi_rdata <= {30'h0, edgeSel_q};
					`OFS_CTRL_PRIMARY:
						s_axi_rdata <= {24'h000000, primaryRd};
					`OFS_CTRL_SECOND:
						s_axi_rdata <= {24'h000000, secondRd};
					`OFS_STATUS:
						s_axi_rdata <= {29'h0, winner};
					default:
					begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= `RESP_SLVERR;
					end
				endcase
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// flags and enables
	// ---------------------------------------------------------------

	// software writes pend or withdraw flags as hardware does; an
	// event in the cycle of a write of zero still sets the flag,
	// since losing a real event is worse than a late clear
	// per-flag set/clear terms; hardware events beat every clear
	always @*
	begin
		flagSet = hwEvent;
		flagClr = 7'h00;
		if (take)
			flagClr[winner] = 1'b1;
		if (doWrite && wStrb_q[0] && awAddr_q == `OFS_CTRL_PRIMARY)
		begin
			flagSet[2:0] = flagSet[2:0] | wData_q[6:4];
			flagClr[2:0] = flagClr[2:0] | ~wData_q[6:4];
		end
		if (doWrite && wStrb_q[0] && awAddr_q == `OFS_CTRL_SECOND)
		begin
			flagSet[6:3] = flagSet[6:3] | wData_q[7:4];
			flagClr[6:3] = flagClr[6:3] | ~wData_q[7:4];
		end
	end

	always @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			edgeSel_q     <= `RST_EDGE_SEL;
			globalEn_q    <= 1'b0;
			srcEn_q       <= 7'h00;
			srcFlag_q     <= 7'h00;
			srcFlagPrev_q <= 7'h00;
		end
		else
		begin
			srcFlag_q     <= flagSet | (srcFlag_q & ~flagClr);
			srcFlagPrev_q <= srcFlag_q;
			if (doWrite && wStrb_q[0])
			begin
				case (awAddr_q)
					`OFS_EDGE_CONFIG:
						edgeSel_q <= wData_q[1:0];
					`OFS_CTRL_PRIMARY:
						srcEn_q[2:0] <= wData_q[3:1];
					`OFS_CTRL_SECOND:
						srcEn_q[6:3] <= wData_q[3:0];
					default:
						edgeSel_q <= edgeSel_q;
				endcase
			end
			// a handler thus always starts with further takes blocked
			// servicing clears global enable; software write loses
			if (take)
				globalEn_q <= 1'b0;
			else if (doWrite && wStrb_q[0] &&
				awAddr_q == `OFS_CTRL_PRIMARY)
				globalEn_q <= wData_q[`BIT_GLOBAL_EN];
		end
	end

	// ---------------------------------------------------------------
	// core side: vectoring, return and wake-up pulses
	// ---------------------------------------------------------------
	// pcLoad, stackPush, stackPop and wakeRequest are registered one-cycle
	// pulses, so the core acts on them at the next edge without decoding any state
	// a take in the cycle of a return wins and the pop is dropped;
	// the core must not retire the return in that cycle
	always @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			pcLoad         <= 1'b0;
			pcLoadValue    <= 12'h000;
			stackPush      <= 1'b0;
			stackPushValue <= 12'h000;
			stackPop       <= 1'b0;
			wakeRequest    <= 1'b0;
		end
		else
		begin
			stackPush <= take;
			stackPop  <= return_from_irq & ~take;
			pcLoad    <= take | return_from_irq;
			if (take)
			begin
				stackPushValue <= nextPc;
				pcLoadValue    <= vectorOf(winner);
			end
			else if (return_from_irq)
				pcLoadValue <= stackTop;
			// only a rising flag wakes; enables are ignored
			wakeRequest <= |(srcFlag_q & ~srcFlagPrev_q);
		end
	end

endmodule

// File: test/core_stack_model.sv
// core model: program counter and a two-entry hardware stack
`timescale 1ns/10ps
// ------
// core
// ------
module core_stack_model
(
	input  wire        clock,
	input  wire        reset,
	input  wire        slow,
	input  wire        doRet,
	input  wire        pcLoad,
	input  wire [11:0] pcLoadValue,
	input  wire        stackPush,
	input  wire [11:0] stackPushValue,
	input  wire        stackPop,
	output wire        instrBoundary,
	output wire [11:0] nextPc,
	output wire        stackFull,
	output wire        return_from_irq,
	output wire [11:0] stackTop
);
	reg [11:0] pc_q;
	reg [11:0] mem_q [0:1];
	reg [1:0]  sp_q;
	reg        ph_q;
	// two entries only, so nesting reaches a full stack quickly
	assign stackFull = sp_q[1];
	assign instrBoundary = !slow || ph_q;
	assign nextPc = pc_q;
	assign return_from_irq = doRet && sp_q != 2'b00;
	// an empty stack shows a scrambled word, never the last entry
	assign stackTop = sp_q == 2'b00 ? ~pc_q : mem_q[sp_q - 2'b01];
	// pc steps per instruction, stack moves on push and pop
	always @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			pc_q <= 12'h100;
			sp_q <= 2'b00;
			ph_q <= 1'b0;
		end
		else
		begin
			ph_q <= !ph_q;
			pc_q <= pcLoad ? pcLoadValue : pc_q + {11'h000, instrBoundary};
			if (stackPush)
				mem_q[sp_q[0]] <= stackPushValue;
			sp_q <= sp_q + {1'b0, stackPush} - {1'b0, stackPop};
		end
	end
endmodule

// File: test/irq_ctrl_properties.sv
// port checker for the interrupt controller core side
`timescale 1ns/10ps
`include "irq_ctrl_regs.vh"
// ------
// checker
// ------
module irq_ctrl_properties
(
	input wire        clock,
	input wire        reset,
	input wire        instrBoundary,
	input wire [11:0] nextPc,
	input wire        stackFull,
	input wire        return_from_irq,
	input wire [11:0] stackTop,
	input wire        pcLoad,
	input wire [11:0] pcLoadValue,
	input wire        stackPush,
	input wire [11:0] stackPushValue,
	input wire        stackPop
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);
	// a take saves the interrupted address and loads a vector
	AST_PUSH_LOAD: assert property (stackPush |-> pcLoad)
		else $error("push without load");
	AST_PUSH_VALUE: assert property (
		stackPush |-> stackPushValue == $past(nextPc))
		else $error("bad pushed address");
	AST_VECTOR: assert property (stackPush |-> pcLoadValue inside
		{`VEC_EXT, `VEC_TOUCH, `VEC_TIMER, `VEC_SERIAL, `VEC_TICK,
		`VEC_NVM, `VEC_ADC})
		else $error("not a vector");
	// full stack or mid-instruction core must hold every take off
	AST_STALL: assert property (
		stackFull || !instrBoundary |=> !stackPush)
		else $error("take while blocked");
	// global enable drops with the take, so takes never come back to back
	AST_ONCE: assert property (stackPush |=> !stackPush)
		else $error("nested take");
	AST_RETURN: assert property (
		return_from_irq |=> stackPop || stackPush)
		else $error("return ignored");
	AST_POP_VALUE: assert property (
		stackPop |-> pcLoad && pcLoadValue == $past(stackTop))
		else $error("bad popped address");
	AST_POP_CAUSE: assert property (
		stackPop |-> $past(return_from_irq) && !stackPush)
		else $error("pop without return");
endmodule

bind vectored_irq_controller irq_ctrl_properties irq_ctrl_properties_inst
(
	.*
);

// File: test/tb_vectored_irq_controller.sv
// self-checking bench for the vectored interrupt controller
`timescale 1ns/10ps
`include "irq_ctrl_regs.vh"
// ------
// bench
// ------
module tb_vectored_irq_controller;
	reg         clock, reset, extPin, extPullHighSel, slow, doRet;
	reg  [7:0]  s_axi_awaddr, s_axi_araddr;
	reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	reg         s_axi_arvalid, s_axi_rready;
	reg  [31:0] s_axi_wdata, rnd, rv;
	reg  [5:0]  ev;
	reg  [11:0] lastVec;
	reg  [6:0]  rem;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire        s_axi_rvalid, extPullHighEn, instrBoundary, stackFull;
	wire        return_from_irq, pcLoad, stackPush, stackPop, wakeRequest;
	wire [1:0]  s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [11:0] nextPc, stackTop, pcLoadValue, stackPushValue;
	integer     miscompares, tests_run, pushes, wakes, w, i, j;

	vectored_irq_controller vectored_irq_controller_inst
	(
		.*, .s_axi_wstrb(4'hf), .touchEvent(ev[0]), .timerEvent(ev[1]),
		.serialEvent(ev[2]), .tickEvent(ev[3]), .nvmEvent(ev[4]),
		.adcEvent(ev[5])
	);
	core_stack_model core_stack_model_inst (.*);

	// clock and counters of takes and wake pulses
	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	always @(posedge clock)
	begin
		pushes <= pushes + stackPush;
		wakes <= wakes + wakeRequest;
		if (stackPush)
			lastVec <= pcLoadValue;
	end

	task chk(input [8*5:1] n, input [31:0] e, input [31:0] g);
	begin
		tests_run = tests_run + 1;
		if (e !== g)
		begin
			miscompares = miscompares + 1;
			$display("MISMATCH %0s expected %h seen %h", n, e, g);
		end
	end
	endtask

	task test_done;
	begin
		if (miscompares == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask

	function [31:0] xs(input [31:0] s);
		reg [31:0] t;
	begin
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		xs = t ^ (t << 5);
	end
	endfunction

	// one register transfer; d[8] set skips the read data compare
	task bus(input wr, input [7:0] a, input [8:0] d, input [1:0] r);
		integer n;
	begin
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= {24'h000000, d[7:0]};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
		{s_axi_arvalid, s_axi_rready} <= {2{!wr}};
		for (n = 0; n < 40; n = n + 1)
		begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_bvalid || s_axi_rvalid) n = 90;
		end
		{s_axi_bready, s_axi_rready} <= 2'b00;
		rv = s_axi_rdata;
		chk("hang", 91, n);
		if (n != 91) test_done;
		chk("resp", r, wr ? s_axi_bresp : s_axi_rresp);
		if (!wr && !d[8]) chk("rdata", d, rv);
	end
	endtask

	// bounded wait for a given number of takes
	task wp(input integer c);
		integer n;
	begin
		for (n = 0; n < 40 && pushes != c; n = n + 1)
			@(posedge clock);
		chk("push", c, pushes);
		if (pushes != c) test_done;
	end
	endtask

	task ret;
	begin
		@(posedge clock);
		doRet <= 1'b1;
		@(posedge clock);
		doRet <= 1'b0;
	end
	endtask

	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
		{s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
		{extPin, extPullHighSel, ev, slow, doRet} = 0;
		{miscompares, tests_run, pushes, wakes} = 0;
		rnd = 32'd48479;
		reset = 1'b1;
		repeat (20) @(posedge clock);
		reset <= 1'b0;
		// reset value, unmapped word, widths with global enable low
		bus(0, 8'h04, 9'h000, 2'b00);
		bus(1, 8'h14, 9'h0ff, 2'b10);
		bus(0, 8'h14, 9'h100, 2'b10);
		bus(1, 8'h00, 9'h0ff, 2'b00);
		bus(0, 8'h00, 9'h003, 2'b00);
		bus(1, 8'h04, 9'h0fe, 2'b00);
		bus(0, 8'h04, 9'h07e, 2'b00);
		rnd = xs(rnd);
		bus(1, 8'h08, {1'b0, rnd[7:0]}, 2'b00);
		bus(0, 8'h08, {1'b0, rnd[7:0]}, 2'b00);
		bus(1, 8'h08, 9'h0ff, 2'b00);
		repeat (9) @(posedge clock);
		chk("push", 0, pushes);
		// seven pending: each global enable serves the next in line
		for (i = 0; i < 7; i = i + 1)
		begin
			bus(0, 8'h04, 9'h100, 2'b00);
			bus(1, 8'h04, {1'b0, rv[7:0] | 8'h01}, 2'b00);
			wp(i + 1);
			chk("vec", `VEC_EXT + 12'h004 * i, lastVec);
			rem = 7'h7f << (i + 1);
			bus(0, 8'h04, {2'b00, rem[2:0], 4'he}, 2'b00);
			bus(0, 8'h08, {1'b0, rem[6:3], 4'hf}, 2'b00);
			ret;
		end
		// two nested takes fill the stack, the third waits for a pop
		slow <= 1'b1;
		bus(1, 8'h08, 9'h0ff, 2'b00);
		for (i = 8; i < 11; i = i + 1)
		begin
			bus(1, 8'h04, 9'h001, 2'b00);
			repeat (9) @(posedge clock);
			chk("push", i < 10 ? i : 9, pushes);
		end
		bus(0, 8'h08, 9'h0cf, 2'b00);
		bus(0, 8'h0c, 9'h005, 2'b00);
		ret;
		wp(10);
		chk("vec", `VEC_NVM, lastVec);
		ret;
		ret;
		// every edge mode, pin enable on and off, both pin edges
		for (i = 0; i < 16; i = i + 1)
		begin
			rnd = xs(rnd);
			extPullHighSel <= rnd[0];
			bus(1, 8'h00, {7'h00, i[2:1]}, 2'b00);
			bus(1, 8'h04, {6'h00, i[3], 1'b0}, 2'b00);
			extPin <= !extPin;
			repeat (5) @(posedge clock);
			chk("pull", rnd[0], extPullHighEn);
			bus(0, 8'h04, {4'h0, i[3] & (i[0] ? i[2] : i[1]), 2'b00,
				i[3], 1'b0}, 2'b00);
		end
		// random events, enables off; a repeat of set flags must not wake
		for (i = 0; i < 6; i = i + 1)
		begin
			bus(1, 8'h04, 9'h000, 2'b00);
			bus(1, 8'h08, 9'h000, 2'b00);
			rnd = xs(rnd);
			for (j = 0; j < 2; j = j + 1)
			begin
				w = wakes;
				@(posedge clock);
				ev <= rnd[5:0];
				@(posedge clock);
				ev <= 6'h00;
				repeat (3) @(posedge clock);
				chk("wake", j == 0 && rnd[5:0] != 0, wakes - w);
			end
			bus(0, 8'h04, {2'b00, rnd[1:0], 5'h00}, 2'b00);
			bus(0, 8'h08, {1'b0, rnd[5:2], 4'h0}, 2'b00);
		end
		test_done;
	end
endmodule
